// ==== pkg/sfif_pkg.sv ====
`default_nettype none
package sfif_pkg;
   // ----------------------------------------
   // Opcodes
   // ----------------------------------------
   localparam logic [7:0] OP_WREN   = 8'h06;
   localparam logic [7:0] OP_WRDI   = 8'h04;
   localparam logic [7:0] OP_RDSR1  = 8'h05;
   localparam logic [7:0] OP_SUSP   = 8'h75;
   localparam logic [7:0] OP_RESM   = 8'h7a;
   localparam logic [7:0] OP_QENTER = 8'h38;
   localparam logic [7:0] OP_QEXIT  = 8'hff;
   localparam logic [7:0] OP_RSTEN  = 8'h66;
   localparam logic [7:0] OP_RST    = 8'h99;
   localparam logic [7:0] OP_GLOCK  = 8'h7e;
   localparam logic [7:0] OP_GUNLK  = 8'h98;
   localparam logic [7:0] OP_BLOCK  = 8'h36;
   localparam logic [7:0] OP_BUNLK  = 8'h39;
   localparam logic [7:0] OP_CE1    = 8'hc7;
   localparam logic [7:0] OP_CE2    = 8'h60;

   // ----------------------------------------
   // Sizes, positions and reset values
   // ----------------------------------------
   localparam int          NUM_BLOCKS   = 64;
   localparam int          BLK_LSB      = 16;
   localparam int          ADDR_BYTES   = 3;
   localparam logic [2:0]  LAST_BIT     = 3'd7;
   localparam logic [63:0] LOCK_RESET   = 64'hffff_ffff_ffff_ffff;
   localparam int          BUF_DEPTH    = 2;

   // Lane width code: step of one, two or four bits per rising clock
   typedef enum logic [1:0] {LANE1, LANE2, LANE4} sfif_lane_t;

   typedef struct packed {
      logic       known;
      logic       wclass;
      logic       need_wel;
      logic       prot_chk;
      logic       is_read;
      logic       has_addr;
      logic [2:0] dummy;
      sfif_lane_t addr_lane;
      sfif_lane_t data_lane;
   } sfif_info_t;

   typedef enum logic [2:0] {EV_READ, EV_DATA, EV_EXEC, EV_DROP, EV_END} sfif_ev_kind_t;

   typedef struct packed {
      sfif_ev_kind_t kind;
      logic [7:0]    opcode;
      logic [23:0]   addr;
      logic [7:0]    data;
   } sfif_ev_t;
endpackage
`default_nettype wire

// ==== verilog/sfif_frontend.sv ====
`default_nettype none
module sfif_frontend (
   input  wire logic             mclk_i,
   input  wire logic             resetn_i,
   input  wire logic             cs_n_i,
   input  wire logic             sclk_i,
   input  wire logic [3:0]       io_i,
   input  wire logic             busy_i,
   input  wire logic             protect_scheme_select_i,
   input  wire logic             ev_ready_i,
   output logic                  ev_valid_o,
   output sfif_pkg::sfif_ev_t    ev_o,
   output logic                  four_line_command_mode_o,
   output logic                  write_enable_latch_o,
   output logic                  overflow_o
);
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [5:0] sync1;
   logic [5:0] sync2;
   logic       cs_prev;
   logic       sclk_prev;

   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         sync1     <= 6'h03;
         sync2     <= 6'h03;
         cs_prev   <= 1'b1;
         sclk_prev <= 1'b1;
      end else begin
         sync1     <= {io_i, sclk_i, cs_n_i};
         sync2     <= sync1;
         cs_prev   <= sync2[0];
         sclk_prev <= sync2[1];
      end
   end

   logic       cs_fall;
   logic       cs_rise;
   logic       sclk_rise;
   logic [3:0] io_s;
   assign cs_fall   = cs_prev && !sync2[0];
   assign cs_rise   = !cs_prev && sync2[0];
   assign sclk_rise = !sync2[0] && !sclk_prev && sync2[1];
   assign io_s      = sync2[5:2];

   // ----------------------------------------
   // Opcode decoder
   // ----------------------------------------
   function automatic sfif_pkg::sfif_info_t decode(input logic [7:0] op, input logic four_line_command_mode);
      sfif_pkg::sfif_info_t d;
      logic                 q_ok;
      d = '0;
      q_ok = 1'b1;
      d.known = 1'b1;
      unique case (op)
         8'h06, 8'h04, 8'h50, 8'hab, 8'hb9, 8'h66, 8'h99, 8'h75, 8'h7a: ;
         8'h38: q_ok = 1'b0;
         8'hff: d.known = four_line_command_mode;
         8'h05, 8'h35, 8'h15, 8'h9f: d.is_read = 1'b1;
         8'h4b: begin
            d.is_read = 1'b1;
            d.dummy   = 3'd4;
            q_ok      = 1'b0;
         end
         8'h90, 8'h03, 8'h3d: begin
            d.is_read  = 1'b1;
            d.has_addr = 1'b1;
            q_ok       = (op != 8'h03);
         end
         8'h0b, 8'h0c, 8'h5a, 8'h48, 8'h3b, 8'h6b: begin
            d.is_read  = 1'b1;
            d.has_addr = 1'b1;
            d.dummy    = 3'd1;
            q_ok       = (op == 8'h0b) || (op == 8'h0c);
            d.known    = (op != 8'h0c) || four_line_command_mode;
         end
         8'hbb, 8'h92, 8'heb, 8'h94: begin
            d.is_read   = 1'b1;
            d.has_addr  = 1'b1;
            d.addr_lane = (op == 8'hbb || op == 8'h92) ? sfif_pkg::LANE2 : sfif_pkg::LANE4;
            d.data_lane = d.addr_lane;
            d.dummy     = (op == 8'heb && four_line_command_mode) ? 3'd1 : (d.addr_lane == sfif_pkg::LANE2 ? 3'd1 : 3'd3);
            q_ok        = (op == 8'heb);
         end
         8'h77: begin
            d.has_addr  = 1'b1;
            d.addr_lane = sfif_pkg::LANE4;
            d.data_lane = sfif_pkg::LANE4;
            q_ok        = 1'b0;
         end
         8'hc0: d.known = four_line_command_mode;
         8'h02, 8'h32, 8'h42: begin
            d.wclass    = 1'b1;
            d.need_wel  = 1'b1;
            d.has_addr  = 1'b1;
            d.prot_chk  = (op != 8'h42);
            d.data_lane = (op == 8'h32) ? sfif_pkg::LANE4 : sfif_pkg::LANE1;
            q_ok        = (op == 8'h02);
         end
         8'h20, 8'h52, 8'hd8, 8'h44, 8'h36, 8'h39: begin
            d.wclass   = 1'b1;
            d.need_wel = 1'b1;
            d.has_addr = 1'b1;
            d.prot_chk = (op == 8'h20) || (op == 8'h52) || (op == 8'hd8);
            q_ok       = (op != 8'h44);
         end
         8'hc7, 8'h60, 8'h01, 8'h31, 8'h11, 8'h7e, 8'h98: begin
            d.wclass   = 1'b1;
            d.need_wel = 1'b1;
            d.prot_chk = (op == sfif_pkg::OP_CE1) || (op == sfif_pkg::OP_CE2);
         end
         default: d.known = 1'b0;
      endcase
      if (four_line_command_mode) begin
         d.known     = d.known && q_ok;
         d.addr_lane = sfif_pkg::LANE4;
         d.data_lane = sfif_pkg::LANE4;
      end
      return d;
   endfunction

   // ----------------------------------------
   // Bit and byte assembly
   // ----------------------------------------
   typedef enum logic [2:0] {PH_IDLE, PH_OP, PH_ADDR, PH_DUMMY, PH_DATA, PH_IGNORE} sfif_phase_t;

   sfif_phase_t          phase;
   sfif_pkg::sfif_info_t info;
   sfif_pkg::sfif_info_t op_info;
   sfif_pkg::sfif_lane_t lane;
   logic [7:0]           shreg;
   logic [7:0]           next_shreg;
   logic [2:0]           bit_cnt;
   logic [3:0]           next_bits;
   logic                 byte_done;
   logic [7:0]           opcode;
   logic [23:0]          addr;
   logic [2:0]           byte_cnt;
   logic                 addr_done;
   logic                 four_line_command_mode;
   logic                 wel;
   logic                 rst_armed;
   logic [63:0]          lock;

   assign lane = (phase == PH_OP) ? (four_line_command_mode ? sfif_pkg::LANE4 : sfif_pkg::LANE1) :
                 (phase == PH_DATA) ? info.data_lane : info.addr_lane;
   assign op_info = decode(next_shreg, four_line_command_mode);

   always_comb begin
      unique case (lane)
         sfif_pkg::LANE1: begin
            next_shreg = {shreg[6:0], io_s[0]};
            next_bits  = {1'b0, bit_cnt} + 4'd1;
         end
         sfif_pkg::LANE2: begin
            next_shreg = {shreg[5:0], io_s[1:0]};
            next_bits  = {1'b0, bit_cnt} + 4'd2;
         end
         default: begin
            next_shreg = {shreg[3:0], io_s};
            next_bits  = {1'b0, bit_cnt} + 4'd4;
         end
      endcase
   end
   assign byte_done = sclk_rise && (next_bits[3] || next_bits[2:0] == 3'd0) && next_bits != 4'd0;

   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         shreg   <= 8'h00;
         bit_cnt <= 3'd0;
      end else if (cs_fall) begin
         shreg   <= 8'h00;
         bit_cnt <= 3'd0;
      end else if (sclk_rise && phase != PH_IDLE) begin
         shreg   <= next_shreg;
         bit_cnt <= next_bits[2:0];
      end
   end

   // ----------------------------------------
   // Instruction sequencer
   // ----------------------------------------
   logic ignore_busy;
   assign ignore_busy = busy_i && next_shreg != sfif_pkg::OP_RDSR1 && next_shreg != sfif_pkg::OP_SUSP;

   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         phase     <= PH_IDLE;
         info      <= '0;
         opcode    <= 8'h00;
         addr      <= 24'h000000;
         byte_cnt  <= 3'd0;
         addr_done <= 1'b0;
      end else if (cs_rise) begin
         phase <= PH_IDLE;
      end else if (cs_fall) begin
         phase     <= PH_OP;
         byte_cnt  <= 3'd0;
         addr_done <= 1'b0;
      end else if (byte_done) begin
         unique case (phase)
            PH_OP: begin
               opcode <= next_shreg;
               info   <= op_info;
               if (!op_info.known || ignore_busy) begin
                  phase <= PH_IGNORE;
               end else if (op_info.has_addr) begin
                  phase <= PH_ADDR;
               end else if (op_info.dummy != 3'd0) begin
                  phase <= PH_DUMMY;
               end else begin
                  phase <= PH_DATA;
               end
            end
            PH_ADDR: begin
               addr     <= {addr[15:0], next_shreg};
               byte_cnt <= byte_cnt + 3'd1;
               if (byte_cnt == 3'(sfif_pkg::ADDR_BYTES - 1)) begin
                  byte_cnt  <= 3'd0;
                  addr_done <= 1'b1;
                  phase     <= (info.dummy != 3'd0) ? PH_DUMMY : PH_DATA;
               end
            end
            PH_DUMMY: begin
               byte_cnt <= byte_cnt + 3'd1;
               if (byte_cnt + 3'd1 == info.dummy) begin
                  phase <= PH_DATA;
               end
            end
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // End of instruction checks
   // ----------------------------------------
   logic locked;
   logic run_ok;
   logic took_op;
   assign took_op = phase != PH_IDLE && phase != PH_OP && phase != PH_IGNORE;
   // Chip erase spans every block, so any set lock bit refuses it when protect_scheme_select_i is set
   assign locked  = protect_scheme_select_i &&
                    (!info.has_addr ? |lock : lock[addr[sfif_pkg::BLK_LSB +: 6]]);
   assign run_ok  = bit_cnt == 3'd0
                    && (!info.need_wel || wel)
                    && (!info.has_addr || addr_done)
                    && !(info.prot_chk && locked);

   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         lock <= sfif_pkg::LOCK_RESET;
      end else if (cs_rise && took_op && info.wclass && run_ok) begin
         unique case (opcode)
            sfif_pkg::OP_GLOCK: lock <= sfif_pkg::LOCK_RESET;
            sfif_pkg::OP_GUNLK: lock <= '0;
            sfif_pkg::OP_BLOCK: lock[addr[sfif_pkg::BLK_LSB +: 6]] <= 1'b1;
            sfif_pkg::OP_BUNLK: lock[addr[sfif_pkg::BLK_LSB +: 6]] <= 1'b0;
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         wel <= 1'b0;
      end else if (cs_rise && took_op && bit_cnt == 3'd0) begin
         if (opcode == sfif_pkg::OP_WREN) begin
            wel <= 1'b1;
         end else if (opcode == sfif_pkg::OP_WRDI || (opcode == sfif_pkg::OP_RST && rst_armed)) begin
            wel <= 1'b0;
         end else if (info.wclass && run_ok) begin
            wel <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         four_line_command_mode       <= 1'b0;
         rst_armed <= 1'b0;
      end else if (cs_rise && took_op) begin
         rst_armed <= opcode == sfif_pkg::OP_RSTEN;
         if (opcode == sfif_pkg::OP_QENTER) begin
            four_line_command_mode <= 1'b1;
         end else if (opcode == sfif_pkg::OP_QEXIT || (opcode == sfif_pkg::OP_RST && rst_armed)) begin
            four_line_command_mode <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Event generation
   // ----------------------------------------
   // Only one event can arise per byte, and a byte lasts far longer than the
   // buffer needs to drain, so a single holding stage suffices ahead of it.
   logic               pend_valid;
   sfif_pkg::sfif_ev_t pend;
   logic               buf_ready;
   logic               new_ev;
   sfif_pkg::sfif_ev_t next_ev;

   always_comb begin
      new_ev  = 1'b0;
      next_ev = '{kind: sfif_pkg::EV_END, opcode: opcode, addr: addr, data: next_shreg};
      if (cs_rise && took_op) begin
         new_ev = 1'b1;
         if (info.wclass) begin
            next_ev.kind = run_ok ? sfif_pkg::EV_EXEC : sfif_pkg::EV_DROP;
         end else if (info.is_read) begin
            next_ev.kind = sfif_pkg::EV_END;
         end else begin
            next_ev.kind = sfif_pkg::EV_EXEC;
         end
      end else if (byte_done && phase == PH_DATA && !info.is_read) begin
         new_ev       = 1'b1;
         next_ev.kind = sfif_pkg::EV_DATA;
      end else if (byte_done && info.is_read &&
                   ((phase == PH_ADDR && byte_cnt == 3'(sfif_pkg::ADDR_BYTES - 1) && info.dummy == 3'd0) ||
                    (phase == PH_DUMMY && byte_cnt + 3'd1 == info.dummy))) begin
         new_ev       = 1'b1;
         next_ev.kind = sfif_pkg::EV_READ;
         next_ev.addr = (phase == PH_ADDR) ? {addr[15:0], next_shreg} : addr;
      end else if (byte_done && phase == PH_OP && op_info.known && !ignore_busy &&
                   op_info.is_read && !op_info.has_addr && op_info.dummy == 3'd0) begin
         new_ev         = 1'b1;
         next_ev.kind   = sfif_pkg::EV_READ;
         next_ev.opcode = next_shreg;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         pend_valid <= 1'b0;
         pend       <= '0;
         overflow_o <= 1'b0;
      end else begin
         if (new_ev) begin
            pend_valid <= 1'b1;
            pend       <= next_ev;
            overflow_o <= overflow_o || (pend_valid && !buf_ready);
         end else if (buf_ready) begin
            pend_valid <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Two-entry event buffer
   // ----------------------------------------
   sfif_pkg::sfif_ev_t mem [sfif_pkg::BUF_DEPTH];
   logic               wptr;
   logic               rptr;
   logic [1:0]         count;
   logic               push;
   logic               pop;

   assign buf_ready  = count != 2'(sfif_pkg::BUF_DEPTH) || ev_ready_i;
   assign push       = pend_valid && buf_ready;
   assign ev_valid_o = count != 2'd0;
   assign pop        = ev_valid_o && ev_ready_i;

   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         wptr  <= 1'b0;
         rptr  <= 1'b0;
         count <= 2'd0;
      end else begin
         wptr  <= wptr ^ push;
         rptr  <= rptr ^ pop;
         count <= count + {1'b0, push} - {1'b0, pop};
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         mem[0] <= '0;
         mem[1] <= '0;
      end else if (push) begin
         mem[wptr] <= pend;
      end
   end

   assign ev_o                     = mem[rptr];
   assign four_line_command_mode_o = four_line_command_mode;
   assign write_enable_latch_o     = wel;
endmodule
`default_nettype wire

// ==== sim/sfif_host.sv ====
`default_nettype none
module sfif_host (
   output logic       cs_n_o,
   output logic       sclk_o,
   output logic [3:0] io_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------
   // Host controller, 125 ns clock
   // ---------------------------------
   // Clock stands low between frames
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      io_o   = 4'h0;
   end
   // Select falls to open a frame
   task automatic start();
      cs_n_o = 1'b0;
      #100;
   endtask
   // Lines change while the clock is low, MSB or high nibble first
   task automatic send(input logic [7:0] b, input int lanes, input int nbits);
      for (int i = 0; i < nbits; i += lanes) begin
         if (lanes == 4) io_o = (i == 0) ? b[7:4] : b[3:0];
         else io_o = {~io_o[3:1], b[7-i]};
         #62 sclk_o = 1'b1;
         #63 sclk_o = 1'b0;
      end
   endtask
   // Select rises to close every frame; released lines show the inverse
   task automatic stop();
      #60 cs_n_o = 1'b1;
      io_o = ~io_o;
      #400;
   endtask
endmodule
`default_nettype wire

// ==== sim/sfif_frontend_sva.sv ====
`default_nettype none
module sfif_frontend_sva (
   input wire logic               mclk_i,
   input wire logic               resetn_i,
   input wire logic               cs_n_i,
   input wire logic               busy_i,
   input wire logic               ev_ready_i,
   input wire logic               ev_valid_o,
   input wire sfif_pkg::sfif_ev_t ev_o,
   input wire logic               four_line_command_mode_o,
   input wire logic               write_enable_latch_o,
   input wire logic               overflow_o
);
   // ---------------------------------
   // Checks
   // ---------------------------------
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);
   logic [5:0] since_cs;
   // Saturates so a long idle gap never wraps into a false frame
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) since_cs <= 6'h3f;
      else if (!cs_n_i) since_cs <= 6'h00;
      else if (since_cs != 6'h3f) since_cs <= since_cs + 6'h01;
   end
   AST_RESET_CLEAR: assert property (disable iff (1'b0) !resetn_i |=> !ev_valid_o && !write_enable_latch_o
      && !four_line_command_mode_o && !overflow_o) else $error("outputs not cleared by reset");
   AST_EV_NEEDS_FRAME: assert property ($rose(ev_valid_o) |-> since_cs < 6'd16)
      else $error("event without a frame");
   AST_EV_HOLD: assert property (ev_valid_o && !ev_ready_i |=> ev_valid_o && $stable(ev_o))
      else $error("event changed while stalled");
   AST_OVF_STICKY: assert property (overflow_o |=> overflow_o) else $error("overflow flag dropped");
   AST_OVF_CAUSE: assert property ($rose(overflow_o) |-> $past(ev_valid_o) && !$past(ev_ready_i))
      else $error("overflow without a stall");
   AST_WEL_AT_END: assert property ($changed(write_enable_latch_o) |-> cs_n_i && since_cs < 6'd16)
      else $error("write enable moved outside frame end");
   AST_MODE_AT_END: assert property ($changed(four_line_command_mode_o) |-> cs_n_i && since_cs < 6'd16)
      else $error("mode moved outside frame end");
   AST_BUSY_NO_WEL: assert property (busy_i [*8] |=> !$rose(write_enable_latch_o))
      else $error("write enable set while busy");
   AST_KIND_LEGAL: assert property (ev_valid_o |-> ev_o.kind <= sfif_pkg::EV_END)
      else $error("illegal event kind");
endmodule
bind sfif_frontend sfif_frontend_sva u_sva (.mclk_i(mclk_i), .resetn_i(resetn_i), .cs_n_i(cs_n_i),
   .busy_i(busy_i), .ev_ready_i(ev_ready_i), .ev_valid_o(ev_valid_o), .ev_o(ev_o),
   .four_line_command_mode_o(four_line_command_mode_o), .write_enable_latch_o(write_enable_latch_o),
   .overflow_o(overflow_o));
`default_nettype wire

// ==== sim/sfif_frontend_bench.sv ====
`default_nettype none
module sfif_frontend_bench;
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------
   // Bench
   // ---------------------------------
   logic               mclk_i = 1'b0;
   logic               resetn_i = 1'b0;
   logic               busy_i = 1'b0;
   logic               protect_scheme_select = 1'b0;
   logic               ev_ready_i = 1'b0;
   wire logic          cs_n;
   wire logic          sclk;
   wire logic [3:0]    io;
   logic               ev_valid_o;
   logic               mode;
   logic               wel;
   logic               ovf;
   sfif_pkg::sfif_ev_t ev_o;
   int                 errors = 0;
   int                 n_compared = 0;
   int                 cycles = 0;
   always #5 mclk_i = ~mclk_i;
   sfif_host hst (.cs_n_o(cs_n), .sclk_o(sclk), .io_o(io));
   sfif_frontend uut (.mclk_i(mclk_i), .resetn_i(resetn_i), .cs_n_i(cs_n), .sclk_i(sclk), .io_i(io),
      .busy_i(busy_i), .protect_scheme_select_i(protect_scheme_select), .ev_ready_i(ev_ready_i), .ev_valid_o(ev_valid_o),
      .ev_o(ev_o), .four_line_command_mode_o(mode), .write_enable_latch_o(wel), .overflow_o(ovf));
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Limit covers all frames with a wide margin
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 60000) begin
         errors++;
         wrap_up();
      end
   end
   task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic frame(input logic [7:0] q[$], input int lanes = 1, input int tail = 0);
      hst.start();
      foreach (q[i]) hst.send(q[i], lanes, 8);
      if (tail > 0) hst.send(8'ha5, 1, tail);
      hst.stop();
   endtask
   task automatic get_ev(input sfif_pkg::sfif_ev_kind_t k, input logic [7:0] op, input logic [23:0] a = 24'h0,
                         input bit use_a = 1'b0);
      int n;
      n = 0;
      @(posedge mclk_i);
      while (ev_valid_o !== 1'b1 && n < 100) begin
         @(posedge mclk_i);
         n++;
      end
      check("event valid", 40'(ev_valid_o), 40'h1);
      check("event kind", 40'(ev_o.kind), 40'(k));
      check("event opcode", 40'(ev_o.opcode), 40'(op));
      if (use_a) check("event address", 40'(ev_o.addr), 40'(a));
      ev_ready_i <= 1'b1;
      @(posedge mclk_i);
      ev_ready_i <= 1'b0;
   endtask
   task automatic no_ev();
      @(posedge mclk_i);
      check("no event", 40'(ev_valid_o), 40'h0);
   endtask
   task automatic t_basic();
      check("idle flags", {37'h0, wel, mode, ovf}, 40'h0);
      frame('{8'h06});
      get_ev(sfif_pkg::EV_EXEC, 8'h06);
      check("wel after 06h", 40'(wel), 40'h1);
      frame('{8'h04});
      get_ev(sfif_pkg::EV_EXEC, 8'h04);
      check("wel after 04h", 40'(wel), 40'h0);
   endtask
   task automatic t_prot();
      frame('{8'h20, 8'h01, 8'h00, 8'h00});
      get_ev(sfif_pkg::EV_DROP, 8'h20);
      frame('{8'h06});
      get_ev(sfif_pkg::EV_EXEC, 8'h06);
      @(posedge mclk_i) protect_scheme_select <= 1'b1;
      frame('{8'h20, 8'h01, 8'h00, 8'h00});
      get_ev(sfif_pkg::EV_DROP, 8'h20);
      @(posedge mclk_i) protect_scheme_select <= 1'b0;
      frame('{8'h20, 8'h01, 8'h00, 8'h00});
      get_ev(sfif_pkg::EV_EXEC, 8'h20, 24'h010000, 1'b1);
      check("wel after erase", 40'(wel), 40'h0);
      frame('{8'h06});
      get_ev(sfif_pkg::EV_EXEC, 8'h06);
      frame('{8'h20, 8'h01, 8'h00, 8'h00}, 1, 3);
      get_ev(sfif_pkg::EV_DROP, 8'h20);
      frame('{8'h04});
      get_ev(sfif_pkg::EV_EXEC, 8'h04);
      @(posedge mclk_i) protect_scheme_select <= 1'b1;
      frame('{8'h06});
      get_ev(sfif_pkg::EV_EXEC, 8'h06);
      frame('{8'h98});
      get_ev(sfif_pkg::EV_EXEC, 8'h98);
      frame('{8'h06});
      get_ev(sfif_pkg::EV_EXEC, 8'h06);
      frame('{8'hc7});
      get_ev(sfif_pkg::EV_EXEC, 8'hc7);
      frame('{8'h06});
      get_ev(sfif_pkg::EV_EXEC, 8'h06);
      frame('{8'h36, 8'h01, 8'h00, 8'h00});
      get_ev(sfif_pkg::EV_EXEC, 8'h36);
      frame('{8'h06});
      get_ev(sfif_pkg::EV_EXEC, 8'h06);
      frame('{8'h20, 8'h02, 8'h00, 8'h00});
      get_ev(sfif_pkg::EV_EXEC, 8'h20, 24'h020000, 1'b1);
      frame('{8'h06});
      get_ev(sfif_pkg::EV_EXEC, 8'h06);
      frame('{8'hc7});
      get_ev(sfif_pkg::EV_DROP, 8'hc7);
      frame('{8'h04});
      get_ev(sfif_pkg::EV_EXEC, 8'h04);
      @(posedge mclk_i) protect_scheme_select <= 1'b0;
   endtask
   task automatic t_read();
      frame('{8'h03, 8'h12, 8'h34, 8'h56}, 1, 5);
      get_ev(sfif_pkg::EV_READ, 8'h03, 24'h123456, 1'b1);
      get_ev(sfif_pkg::EV_END, 8'h03);
      frame('{8'h0b, 8'h65, 8'h43, 8'h21, 8'h00});
      get_ev(sfif_pkg::EV_READ, 8'h0b, 24'h654321, 1'b1);
      get_ev(sfif_pkg::EV_END, 8'h0b);
   endtask
   task automatic t_busy();
      @(posedge mclk_i) busy_i <= 1'b1;
      frame('{8'h06});
      no_ev();
      check("wel while busy", 40'(wel), 40'h0);
      frame('{8'h05});
      get_ev(sfif_pkg::EV_READ, 8'h05);
      get_ev(sfif_pkg::EV_END, 8'h05);
      frame('{8'h75});
      get_ev(sfif_pkg::EV_EXEC, 8'h75);
      @(posedge mclk_i) busy_i <= 1'b0;
      frame('{8'h7a});
      get_ev(sfif_pkg::EV_EXEC, 8'h7a);
   endtask
   task automatic t_qpi();
      frame('{8'h38});
      get_ev(sfif_pkg::EV_EXEC, 8'h38);
      check("mode on", 40'(mode), 40'h1);
      frame('{8'h06}, 4);
      get_ev(sfif_pkg::EV_EXEC, 8'h06);
      check("wel in four-line", 40'(wel), 40'h1);
      frame('{8'h66}, 4);
      get_ev(sfif_pkg::EV_EXEC, 8'h66);
      frame('{8'h99}, 4);
      get_ev(sfif_pkg::EV_EXEC, 8'h99);
      check("flags after reset pair", {38'h0, wel, mode}, 40'h0);
      frame('{8'h38});
      get_ev(sfif_pkg::EV_EXEC, 8'h38);
      frame('{8'hff}, 4);
      get_ev(sfif_pkg::EV_EXEC, 8'hff);
      check("mode off", 40'(mode), 40'h0);
   endtask
   task automatic t_buf();
      for (int i = 0; i < 4; i++) frame('{(i % 2) ? 8'h7a : 8'h75});
      check("overflow", 40'(ovf), 40'h1);
      get_ev(sfif_pkg::EV_EXEC, 8'h75);
      get_ev(sfif_pkg::EV_EXEC, 8'h7a);
      get_ev(sfif_pkg::EV_EXEC, 8'h7a);
      @(posedge mclk_i);
      check("drained", 40'(ev_valid_o), 40'h0);
   endtask
   initial begin
      repeat (2) @(posedge mclk_i);
      resetn_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      t_basic();
      t_prot();
      t_read();
      t_busy();
      t_qpi();
      t_buf();
      wrap_up();
   end
endmodule
`default_nettype wire
